// *** lcdh_pkg.sv ***
// package for the segment lcd host sequencer
// What this block does
// - host writes zero to mode bits 0,1,3,5
// - stop order: display, pins, static, booster
// - start order: booster, wait 500 ms, slices, pins, display
// - only combinations 000,010,011,111 used
// - main clock source: display off, static before stop
// - static mode chosen before booster start
// - clock register resets zero, upper bits zero
// - frame rate at most 128 Hz, source 32 kHz
// - clock register changed only when off
// - boost level resets zero, only bit 0
// - boost level changed only with booster off
// - booster left on at stop if any shared pin is port
package lcdh_pkg;
	localparam logic [15:0] ADDR_PORT_SEG   = 16'hff58;
	localparam logic [15:0] ADDR_MODE       = 16'hffb0;
	localparam logic [15:0] ADDR_CLOCK      = 16'hffb2;
	localparam logic [15:0] ADDR_BOOST      = 16'hffb3;
	localparam logic [7:0]  MODE_DISPLAY_ON = 8'h80;
	localparam logic [7:0]  MODE_BOOSTER_ON = 8'h40;
	localparam logic [7:0]  MODE_PIN_OUTPUT = 8'h10;
	localparam logic [7:0]  MODE_STATIC     = 8'h04;
	localparam logic [7:0]  CLOCK_MASK      = 8'h0f;
	localparam logic [7:0]  BOOST_MASK      = 8'h01;
	localparam logic [7:0]  PORT_SEG_MASK   = 8'h3f;
	localparam int          PORT_PINS       = 6;
	localparam int          CLK_HZ          = 25000000;
	localparam int          BOOST_WAIT_MS   = 500;
	localparam longint      BOOST_WAIT_CYC  = (longint'(CLK_HZ) * BOOST_WAIT_MS + 999) / 1000;
	localparam int          WRITE_GAP_CYC   = 1;
	typedef struct packed {
		logic [7:0] clock_ctl;
		logic [7:0] boost_lvl;
		logic [7:0] port_seg;
	} lcdh_cfg_s;
	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  data;
	} lcdh_bus_s;
	typedef enum logic [3:0] {
		ST_IDLE     = 4'b0000,
		ST_STATIC0  = 4'b0001,
		ST_CLOCK    = 4'b0010,
		ST_BOOST    = 4'b0011,
		ST_PORT     = 4'b0100,
		ST_BOOST_ON = 4'b0101,
		ST_WAIT     = 4'b0110,
		ST_SLICES   = 4'b0111,
		ST_PINS_ON  = 4'b1000,
		ST_DISP_ON  = 4'b1001,
		ST_DISP_OFF = 4'b1010,
		ST_PINS_OFF = 4'b1011,
		ST_STATIC1  = 4'b1100,
		ST_BOOST_OFF= 4'b1101,
		ST_GAP      = 4'b1110
	} lcdh_state_e;
endpackage

// *** lcdh_wait.sv ***
// counter that times the booster settling wait
`timescale 1ns/1ps
`default_nettype none
module lcdh_wait #(
	parameter longint WAIT_CYC = 64'd12500000
) (
	input  wire logic core_clk_i,
	input  wire logic reset_i,
	input  wire logic start_i,
	output logic      done_o
);
	logic [31:0] cnt_reg;
	logic        busy_reg;
	localparam logic [31:0] LAST = 32'(WAIT_CYC - 1);
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			cnt_reg  <= 32'h0;
			busy_reg <= 1'b0;
			done_o   <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				cnt_reg  <= 32'h0;
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (cnt_reg >= LAST) begin
					busy_reg <= 1'b0;
					done_o   <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg + 32'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** lcdh_ctrl.sv ***
// host sequencer that powers the segment lcd up and down through its registers
`timescale 1ns/1ps
`default_nettype none
module lcdh_ctrl
	import lcdh_pkg::*;
#(
	parameter longint WAIT_CYC = BOOST_WAIT_CYC
) (
	input  wire logic              core_clk_i,
	input  wire logic              reset_i,
	input  wire logic              start_i,
	input  wire logic              stop_i,
	input  wire lcdh_pkg::lcdh_cfg_s cfg_i,
	input  wire logic              bus_ready_i,
	output lcdh_pkg::lcdh_bus_s    bus_o,
	output logic                   display_active_o,
	output logic                   busy_o
);
	import lcdh_pkg::*;

	lcdh_state_e state_reg, state_next, ret_reg, ret_next;
	lcdh_bus_s   bus_next;
	logic        wait_start;
	logic        wait_done;
	logic        active_next;
	logic [7:0]  mode_reg, mode_next;
	lcdh_cfg_s   cfg_reg;
	logic        go_up;
	logic        go_down;
	// named step values keep every case item but ST_STATIC1 to plain selection
	logic [7:0]  mode_static_set;
	logic [7:0]  mode_booster_set;
	logic [7:0]  mode_slices_set;
	logic [7:0]  mode_pins_set;
	logic [7:0]  mode_display_set;
	logic [7:0]  mode_display_clr;
	logic [7:0]  mode_pins_clr;
	logic [7:0]  mode_booster_clr;
	logic [7:0]  clock_wr_data;
	logic [7:0]  boost_wr_data;
	logic [7:0]  port_wr_data;
	logic [PORT_PINS-1:0] pin_is_port;
	logic        any_port_pin;
	logic        write_acked;

	// requests only honoured while idle; one shot per pulse
	assign go_up   = start_i && !display_active_o;
	assign go_down = stop_i && display_active_o;

	// next mode byte per step; single-bit masks never touch the reserved bits
	assign mode_static_set  = MODE_STATIC;
	assign mode_booster_set = mode_reg | MODE_BOOSTER_ON;
	assign mode_slices_set  = mode_reg & ~MODE_STATIC;
	assign mode_pins_set    = mode_reg | MODE_PIN_OUTPUT;
	assign mode_display_set = mode_reg | MODE_DISPLAY_ON;
	assign mode_display_clr = mode_reg & ~MODE_DISPLAY_ON;
	assign mode_pins_clr    = mode_reg & ~MODE_PIN_OUTPUT;
	assign mode_booster_clr = mode_reg & ~MODE_BOOSTER_ON;

	// config bytes masked so unused register bits always go out as zero
	assign clock_wr_data = cfg_reg.clock_ctl & CLOCK_MASK;
	assign boost_wr_data = cfg_reg.boost_lvl & BOOST_MASK;
	assign port_wr_data  = cfg_reg.port_seg & PORT_SEG_MASK;

	// a zero bit leaves its shared pin a plain port, which needs the booster
	genvar g;
	generate
		for (g = 0; g < PORT_PINS; g++) begin : g_pin
			assign pin_is_port[g] = !port_wr_data[g];
		end
	endgenerate
	// at stop, only when every shared pin is a segment may the booster be stopped
	assign any_port_pin = |pin_is_port;
	// a write ends only on the edge at which the device accepts it
	assign write_acked  = bus_o.wr && bus_ready_i;

	lcdh_wait #(.WAIT_CYC(WAIT_CYC)) u_wait (
		.core_clk_i (core_clk_i),
		.reset_i    (reset_i),
		.start_i    (wait_start),
		.done_o     (wait_done)
	);

	// each write step issues one bus write, then parks in gap until ack
	always_comb begin
		state_next  = state_reg;
		ret_next    = ret_reg;
		mode_next   = mode_reg;
		active_next = display_active_o;
		bus_next    = bus_o;
		bus_next.wr = 1'b0;
		wait_start  = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (go_up) begin
					state_next = ST_STATIC0;
				end else if (go_down) begin
					state_next = ST_DISP_OFF;
				end
			end
			ST_STATIC0: begin
				mode_next  = mode_static_set;
				bus_next   = '{wr: 1'b1, addr: ADDR_MODE, data: mode_static_set};
				ret_next   = ST_CLOCK;
				state_next = ST_GAP;
			end
			ST_CLOCK: begin
				// booster and display are off here, so clock may change
				bus_next   = '{wr: 1'b1, addr: ADDR_CLOCK, data: clock_wr_data};
				ret_next   = ST_BOOST;
				state_next = ST_GAP;
			end
			ST_BOOST: begin
				bus_next   = '{wr: 1'b1, addr: ADDR_BOOST, data: boost_wr_data};
				ret_next   = ST_PORT;
				state_next = ST_GAP;
			end
			ST_PORT: begin
				bus_next   = '{wr: 1'b1, addr: ADDR_PORT_SEG, data: port_wr_data};
				ret_next   = ST_BOOST_ON;
				state_next = ST_GAP;
			end
			ST_BOOST_ON: begin
				mode_next  = mode_booster_set;
				bus_next   = '{wr: 1'b1, addr: ADDR_MODE, data: mode_booster_set};
				ret_next   = ST_WAIT;
				state_next = ST_GAP;
			end
			ST_WAIT: begin
				// the settle time is counted, the device gives no ready sign for it
				if (wait_done) begin
					state_next = ST_SLICES;
				end
			end
			ST_SLICES: begin
				mode_next  = mode_slices_set;
				bus_next   = '{wr: 1'b1, addr: ADDR_MODE, data: mode_slices_set};
				ret_next   = ST_PINS_ON;
				state_next = ST_GAP;
			end
			ST_PINS_ON: begin
				mode_next  = mode_pins_set;
				bus_next   = '{wr: 1'b1, addr: ADDR_MODE, data: mode_pins_set};
				ret_next   = ST_DISP_ON;
				state_next = ST_GAP;
			end
			ST_DISP_ON: begin
				mode_next   = mode_display_set;
				bus_next    = '{wr: 1'b1, addr: ADDR_MODE, data: mode_display_set};
				active_next = 1'b1;
				ret_next    = ST_IDLE;
				state_next  = ST_GAP;
			end
			ST_DISP_OFF: begin
				mode_next   = mode_display_clr;
				bus_next    = '{wr: 1'b1, addr: ADDR_MODE, data: mode_display_clr};
				active_next = 1'b0;
				ret_next    = ST_PINS_OFF;
				state_next  = ST_GAP;
			end
			ST_PINS_OFF: begin
				mode_next  = mode_pins_clr;
				bus_next   = '{wr: 1'b1, addr: ADDR_MODE, data: mode_pins_clr};
				ret_next   = ST_STATIC1;
				state_next = ST_GAP;
			end
			ST_STATIC1: begin
				mode_next  = mode_reg | mode_static_set;
				bus_next   = '{wr: 1'b1, addr: ADDR_MODE, data: mode_reg | mode_static_set};
				ret_next   = ST_BOOST_OFF;
				state_next = ST_GAP;
			end
			ST_BOOST_OFF: begin
				// booster stays on when a shared pin is a plain port
				if (!any_port_pin) begin
					mode_next = mode_booster_clr;
					bus_next  = '{wr: 1'b1, addr: ADDR_MODE, data: mode_booster_clr};
					ret_next  = ST_IDLE;
					state_next = ST_GAP;
				end else begin
					state_next = ST_IDLE;
				end
			end
			ST_GAP: begin
				// holding the byte until accepted keeps slow devices from losing it
				if (write_acked) begin
					state_next = ret_reg;
					wait_start = (ret_reg == ST_WAIT);
				end else begin
					bus_next.wr = bus_o.wr;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			state_reg        <= ST_IDLE;
			ret_reg          <= ST_IDLE;
			mode_reg         <= 8'h00;
			bus_o            <= '0;
			display_active_o <= 1'b0;
			busy_o           <= 1'b0;
			cfg_reg          <= '0;
		end else begin
			state_reg        <= state_next;
			ret_reg          <= ret_next;
			mode_reg         <= mode_next;
			bus_o            <= bus_next;
			display_active_o <= active_next;
			busy_o           <= (state_next != ST_IDLE);
			if (state_reg == ST_IDLE && go_up) begin
				cfg_reg <= cfg_i; // left to the caller's settings
			end
		end
	end
endmodule
`default_nettype wire

// *** lcdh_dev_model.sv ***
// register model of the lcd block answering the host sequencer
`timescale 1ns/1ps
`default_nettype none
module lcdh_dev_model
	import lcdh_pkg::*;
(
	input	wire logic		core_clk_i,
	input	wire logic		reset_i,
	input	wire logic		slow_i,
	input	wire lcdh_pkg::lcdh_bus_s	bus_i,
	output	logic			ready_o
);
	logic [7:0]	mode_reg, clock_reg, boost_reg, port_reg;
	logic [1:0]	hold_reg;
	logic [23:0]	log_q[$];
	logic [1:0]	sync_q;
	logic [1:0]	slot_reg;
	logic		seg_sel;
	logic [11:0]	frame_div;
	localparam logic [3:0] CELL = 4'hd;
	// panel logic sees display enable two flops late; slot k shows cell bit k
	assign seg_sel = sync_q[1] && CELL[slot_reg];
	// source ticks per frame: slot clock divider times four slices
	assign frame_div = 12'h100 << clock_reg[1:0];
	// slow answers stretch each write to four cycles
	assign ready_o = bus_i.wr && (!slow_i || hold_reg == 2'h3);
	always @(posedge core_clk_i) begin
		hold_reg <= (bus_i.wr && !ready_o) ? hold_reg + 2'h1 : 2'h0;
		sync_q <= {sync_q[0], mode_reg[7]};
		slot_reg <= sync_q[1] ? slot_reg + 2'h1 : 2'h0;
		if (reset_i) begin
			mode_reg <= 8'h00;
			clock_reg <= 8'h00;
			boost_reg <= 8'h00;
			port_reg <= 8'h00;
		end else if (ready_o) begin
			log_q.push_back({bus_i.addr, bus_i.data});
			case (bus_i.addr)
				ADDR_MODE: mode_reg <= bus_i.data;
				ADDR_CLOCK: clock_reg <= bus_i.data;
				ADDR_BOOST: boost_reg <= bus_i.data;
				ADDR_PORT_SEG: port_reg <= bus_i.data;
				default: ;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** lcdh_ctrl_assertions.sv ***
// port checks for the lcd host sequencer
`timescale 1ns/1ps
`default_nettype none
module lcdh_ctrl_assertions
	import lcdh_pkg::*;
#(
	parameter longint WAIT_CYC = BOOST_WAIT_CYC
) (
	input	wire logic		core_clk_i,
	input	wire logic		reset_i,
	input	wire logic		start_i,
	input	wire logic		stop_i,
	input	wire lcdh_pkg::lcdh_cfg_s	cfg_i,
	input	wire logic		bus_ready_i,
	input	wire lcdh_pkg::lcdh_bus_s	bus_o,
	input	wire logic		display_active_o,
	input	wire logic		busy_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	logic	is_mode;
	assign is_mode = bus_o.wr && bus_o.addr == ADDR_MODE;
	sequence s_ack;
		bus_o.wr && bus_ready_i;
	endsequence
	sequence s_mode(logic [7:0] v);
		is_mode && bus_o.data == v;
	endsequence
	AST_HOLD: assert property (bus_o.wr && !bus_ready_i |=> $stable(bus_o))
		else $error("write changed before ack");
	AST_GAP: assert property (s_ack |=> !bus_o.wr)
		else $error("no idle cycle after ack");
	AST_RSV: assert property (is_mode |-> (bus_o.data & 8'h2b) == 8'h00)
		else $error("mode reserved bits set");
	AST_CLK: assert property (bus_o.wr && bus_o.addr == ADDR_CLOCK |-> bus_o.data[7:4] == 4'h0)
		else $error("clock upper bits set");
	AST_BST: assert property (bus_o.wr && bus_o.addr == ADDR_BOOST |-> bus_o.data[7:1] == 7'h00)
		else $error("boost upper bits set");
	AST_COMBO: assert property (is_mode |-> {bus_o.data[7:6], bus_o.data[4]} inside {3'b000, 3'b010, 3'b011, 3'b111})
		else $error("prohibited on/boost/pin mix");
	AST_START: assert property (start_i && !busy_o && !display_active_o |=> ##1 s_mode(8'h04))
		else $error("start not opened with static");
	AST_STOP: assert property (stop_i && !busy_o && display_active_o |=> ##1 s_mode(8'h50))
		else $error("stop not opened with display off");
	AST_WAIT: assert property (s_ack ##0 s_mode(8'h44) |=> !bus_o.wr [*8])
		else $error("booster settle wait cut short");
	AST_ON: assert property ($rose(display_active_o) |-> s_mode(8'hd0))
		else $error("active flag without display on");
endmodule
bind lcdh_ctrl lcdh_ctrl_assertions #(.WAIT_CYC(WAIT_CYC)) i_lcdh_ctrl_assertions (
	.core_clk_i(core_clk_i), .reset_i(reset_i), .start_i(start_i), .stop_i(stop_i),
	.cfg_i(cfg_i), .bus_ready_i(bus_ready_i), .bus_o(bus_o),
	.display_active_o(display_active_o), .busy_o(busy_o));
`default_nettype wire

// *** test_lcdh_ctrl.sv ***
// self-checking bench for the lcd host sequencer
`timescale 1ns/1ps
`default_nettype none
module test_lcdh_ctrl;
	import lcdh_pkg::*;
	logic		core_clk_i = 1'b0;
	logic		reset_i = 1'b1;
	logic		start_i = 1'b0;
	logic		stop_i = 1'b0;
	logic		slow = 1'b0;
	lcdh_cfg_s	cfg_i = '0;
	lcdh_bus_s	bus_o;
	logic		bus_ready_i, display_active_o, busy_o;
	int		n_fail = 0;
	int		total_checks = 0;
	int		cycles = 0;
	logic [23:0]	exp_q[$];
	always #20 core_clk_i = ~core_clk_i;
	// short settle wait keeps the run brief
	lcdh_ctrl #(.WAIT_CYC(64'd10)) i_lcdh_ctrl (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.start_i(start_i), .stop_i(stop_i), .cfg_i(cfg_i), .bus_ready_i(bus_ready_i),
		.bus_o(bus_o), .display_active_o(display_active_o), .busy_o(busy_o));
	lcdh_dev_model i_lcdh_dev_model (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.slow_i(slow), .bus_i(bus_o), .ready_o(bus_ready_i));
	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic req(input logic up, input logic taken);
		i_lcdh_dev_model.log_q.delete();
		@(posedge core_clk_i);
		start_i <= up;
		stop_i <= !up;
		@(posedge core_clk_i);
		start_i <= 1'b0;
		stop_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		chk("busy", 24'(busy_o), 24'(taken));
		while (busy_o !== 1'b0) @(posedge core_clk_i);
	endtask
	task automatic chk_log(input string what);
		chk({what, " count"}, 24'(i_lcdh_dev_model.log_q.size()), 24'(exp_q.size()));
		foreach (exp_q[k]) chk(what, i_lcdh_dev_model.log_q[k], exp_q[k]);
		$display("test %s done", what);
	endtask
	task automatic t_reset;
		chk("mode reset", 24'(i_lcdh_dev_model.mode_reg), 24'h0);
		chk("clock reset", 24'(i_lcdh_dev_model.clock_reg), 24'h0);
		chk("boost reset", 24'(i_lcdh_dev_model.boost_reg), 24'h0);
		chk("port reset", 24'(i_lcdh_dev_model.port_reg), 24'h0);
		$display("test reset done");
	endtask
	task automatic t_up(input lcdh_cfg_s c, input logic s);
		@(posedge core_clk_i);
		cfg_i <= c;
		slow <= s;
		exp_q = '{{ADDR_MODE, 8'h04}, {ADDR_CLOCK, c.clock_ctl & CLOCK_MASK},
			{ADDR_BOOST, c.boost_lvl & BOOST_MASK}, {ADDR_PORT_SEG, c.port_seg & PORT_SEG_MASK},
			{ADDR_MODE, 8'h44}, {ADDR_MODE, 8'h40}, {ADDR_MODE, 8'h50}, {ADDR_MODE, 8'hd0}};
		req(1'b1, 1'b1);
		chk_log("power up");
		chk("active", 24'(display_active_o), 24'h1);
		repeat (2) @(posedge core_clk_i);
		chk("sync on", 24'(i_lcdh_dev_model.sync_q[1]), 24'h1);
		chk("frame", 24'(i_lcdh_dev_model.frame_div), 24'((64 << c.clock_ctl[1:0]) * 4));
	endtask
	task automatic t_down;
		exp_q = '{{ADDR_MODE, 8'h50}, {ADDR_MODE, 8'h40}, {ADDR_MODE, 8'h44}};
		if (cfg_i.port_seg[5:0] == 6'h3f) exp_q.push_back({ADDR_MODE, 8'h04});
		req(1'b0, 1'b1);
		chk_log("power down");
		chk("segments off", 24'(i_lcdh_dev_model.seg_sel), 24'h0);
		chk("booster kept", 24'(i_lcdh_dev_model.mode_reg[6]), 24'(exp_q.size() == 3));
		chk("inactive", 24'(display_active_o), 24'h0);
	endtask
	task automatic t_refuse(input logic up);
		exp_q.delete();
		req(up, 1'b0);
		chk_log("refused");
	endtask
	task automatic t_mid_reset;
		@(posedge core_clk_i);
		start_i <= 1'b1;
		@(posedge core_clk_i);
		start_i <= 1'b0;
		repeat (6) @(posedge core_clk_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		chk("busy after reset", 24'(busy_o), 24'h0);
		chk("active after reset", 24'(display_active_o), 24'h0);
		chk("bus after reset", 24'(bus_o.wr), 24'h0);
		chk("mode after reset", 24'(i_lcdh_dev_model.mode_reg), 24'h0);
		$display("test mid reset done");
	endtask
	initial begin
		repeat (4) @(posedge core_clk_i);
		reset_i <= 1'b0;
		@(posedge core_clk_i);
		t_reset();
		t_up('{8'hff, 8'hff, 8'hff}, 1'b0);
		t_refuse(1'b1);
		t_down();
		t_refuse(1'b0);
		t_up('{8'h05, 8'h00, 8'h15}, 1'b1);
		t_down();
		t_mid_reset();
		t_refuse(1'b0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
